// ==== src/internal_osc_suspend_ctrl.sv ====
/*
 * Internal oscillator control: enable, frequency-ready flag, core clock
 * divide selection and forced suspend with USB and VBUS wake-up.
 * Assumes one 10 MHz clock; usb_nonidle and vbus_level come from the
 * transceiver and level detector asynchronously and are synchronised here.
 */
// Overview of operation
// R1: Writing one to force-suspend stops the internal oscillator. The code leaves it running when a wake condition is present in the write cycle.
// R2: Suspend holds until non-idle USB activity or VBUS matches chosen polarity.
// R3: Non-idle activity wakes the oscillator even with the transceiver disabled.
// R4: Non-idle USB activity during suspend raises the resume interrupt.
// R5: Software should set transceiver enable after a resume interrupt.
// R6: Oscillator enable bit zero disables, one enables the oscillator.
// R7: Frequency-ready reads one only while oscillator runs at programmed frequency.
// R8: Divide code 10 divides by two, code 11 by one.
// R9: After reset the oscillator drives the core clock, divided by eight.
// R10: Divide code 00 divides by eight, code 01 by four.
module internal_osc_suspend_ctrl (
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   input  wire osc_ctrl_pkg::reg_req_t reg_req,
   output logic [7:0]                  rd_data,
   input  wire logic                   usb_nonidle,
   input  wire logic                   vbus_level,
   output logic                        osc_running,
   output logic                        core_clock_en,
   output logic                        transceiver_enable,
   output logic                        irq
);

   logic       usb_meta_q;
   logic       usb_sync_q;
   logic       usb_prev_q;
   logic       vbus_meta_q;
   logic       vbus_sync_q;
   logic       osc_enable_q;
   logic       osc_enable_d;
   logic       suspend_q;
   logic       suspend_d;
   logic [1:0] osc_div_select_q;
   logic       vbus_polarity_select_q;
   logic       transceiver_enable_q;
   logic [osc_ctrl_pkg::INT_BITS-1:0] int_status_q;
   logic [osc_ctrl_pkg::INT_BITS-1:0] int_mask_q;
   logic       osc_running_q;
   logic       osc_running_d;
   logic       osc_freq_ready_q;
   logic [3:0] settle_cnt_q;
   logic [2:0] div_cnt_q;
   logic [2:0] div_limit;
   logic       core_clock_en_q;
   logic       irq_q;
   logic [7:0] rd_data_q;
   logic       wr_osc;
   logic       usb_wake;
   logic       vbus_wake;
   logic       wake;

   localparam logic [3:0] SETTLE_LAST = 4'(osc_ctrl_pkg::OSC_SETTLE_CYC - 1);

   // Two-stage synchronisers; the second stage feeds the logic, and usb_prev_q delays it once more for the resume edge detect.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         usb_meta_q  <= 1'b0;
         usb_sync_q  <= 1'b0;
         usb_prev_q  <= 1'b0;
         vbus_meta_q <= 1'b0;
         vbus_sync_q <= 1'b0;
      end else begin
         usb_meta_q  <= usb_nonidle;
         usb_sync_q  <= usb_meta_q;
         usb_prev_q  <= usb_sync_q;
         vbus_meta_q <= vbus_level;
         vbus_sync_q <= vbus_meta_q;
      end
   end

   assign wr_osc = reg_req.wr && (reg_req.addr == osc_ctrl_pkg::ADDR_INTERNAL_OSC_CONTROL);
   // The transceiver enable does not gate detection, so wake never depends on it. [R3]
   assign usb_wake  = usb_sync_q;
   assign vbus_wake = (vbus_sync_q == vbus_polarity_select_q);
   assign wake      = usb_wake || vbus_wake;

   always_comb begin
      osc_enable_d = osc_enable_q;
      suspend_d    = suspend_q;
      if (wr_osc) begin
         osc_enable_d = reg_req.wdata[osc_ctrl_pkg::BIT_OSC_ENABLE]; // [R6]
         if (reg_req.wdata[osc_ctrl_pkg::BIT_FORCE_SUSPEND]) begin
            suspend_d = 1'b1; // [R1]
         end
      end
      // A wake condition present in the write cycle wins, so it is not missed.
      if (suspend_d && wake) begin
         suspend_d = 1'b0; // [R2]
      end
      osc_running_d = osc_enable_d && !suspend_d; // [R1] [R6]
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_enable_q  <= osc_ctrl_pkg::OSC_CONTROL_RESET[osc_ctrl_pkg::BIT_OSC_ENABLE]; // [R9]
         suspend_q     <= 1'b0;
         osc_running_q <= osc_ctrl_pkg::OSC_CONTROL_RESET[osc_ctrl_pkg::BIT_OSC_ENABLE];
      end else begin
         osc_enable_q  <= osc_enable_d;
         suspend_q     <= suspend_d;
         osc_running_q <= osc_running_d;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_div_select_q <= osc_ctrl_pkg::OSC_CONTROL_RESET[osc_ctrl_pkg::BIT_DIV_HI:
                                                             osc_ctrl_pkg::BIT_DIV_LO]; // [R9]
      end else if (wr_osc) begin
         osc_div_select_q <= reg_req.wdata[osc_ctrl_pkg::BIT_DIV_HI:osc_ctrl_pkg::BIT_DIV_LO];
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         vbus_polarity_select_q <=
            osc_ctrl_pkg::WAKE_CONTROL_RESET[osc_ctrl_pkg::BIT_VBUS_POLARITY];
         transceiver_enable_q   <=
            osc_ctrl_pkg::WAKE_CONTROL_RESET[osc_ctrl_pkg::BIT_TRANSCEIVER_EN];
      end else if (reg_req.wr && reg_req.addr == osc_ctrl_pkg::ADDR_WAKE_CONTROL) begin
         vbus_polarity_select_q <= reg_req.wdata[osc_ctrl_pkg::BIT_VBUS_POLARITY];
         transceiver_enable_q   <= reg_req.wdata[osc_ctrl_pkg::BIT_TRANSCEIVER_EN];
      end
   end

   // Frequency-ready rises only after the start-up time of a fresh start. [R7]
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         settle_cnt_q     <= '0;
         osc_freq_ready_q <= 1'b0;
      end else if (!osc_running_d) begin
         settle_cnt_q     <= '0;
         osc_freq_ready_q <= 1'b0; // [R7]
      end else if (osc_running_q && !osc_freq_ready_q) begin
         if (settle_cnt_q == SETTLE_LAST) begin
            osc_freq_ready_q <= 1'b1; // [R7]
         end else begin
            settle_cnt_q <= settle_cnt_q + 4'h1;
         end
      end
   end

   always_comb begin
      unique case (osc_div_select_q)
         osc_ctrl_pkg::DIV_BY8: div_limit = osc_ctrl_pkg::LIMIT_BY8; // [R10] [R9]
         osc_ctrl_pkg::DIV_BY4: div_limit = osc_ctrl_pkg::LIMIT_BY4; // [R10]
         osc_ctrl_pkg::DIV_BY2: div_limit = osc_ctrl_pkg::LIMIT_BY2; // [R8]
         osc_ctrl_pkg::DIV_BY1: div_limit = osc_ctrl_pkg::LIMIT_BY1; // [R8]
      endcase
   end

   // Core clock enable is one pulse per divided oscillator period. The
   // greater-or-equal test recovers at once when the divisor shrinks.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_q       <= '0;
         core_clock_en_q <= 1'b0;
      end else if (!osc_running_q) begin
         div_cnt_q       <= '0;
         core_clock_en_q <= 1'b0;
      end else if (div_cnt_q >= div_limit) begin
         div_cnt_q       <= '0;
         core_clock_en_q <= 1'b1; // [R8] [R10]
      end else begin
         div_cnt_q       <= div_cnt_q + 3'h1;
         core_clock_en_q <= 1'b0;
      end
   end

   // Sticky status: a new event in the clearing cycle keeps its bit set.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         int_status_q <= osc_ctrl_pkg::INT_RESET[osc_ctrl_pkg::INT_BITS-1:0];
         int_mask_q   <= osc_ctrl_pkg::INT_RESET[osc_ctrl_pkg::INT_BITS-1:0];
      end else begin
         if (reg_req.wr && reg_req.addr == osc_ctrl_pkg::ADDR_INT_MASK) begin
            int_mask_q <= reg_req.wdata[osc_ctrl_pkg::INT_BITS-1:0];
         end
         int_status_q <= (int_status_q
                          & ~((reg_req.wr && reg_req.addr == osc_ctrl_pkg::ADDR_INT_STATUS)
                              ? reg_req.wdata[osc_ctrl_pkg::INT_BITS-1:0]
                              : osc_ctrl_pkg::INT_RESET[osc_ctrl_pkg::INT_BITS-1:0]))
                         | {suspend_q && vbus_wake,
                            suspend_q && usb_sync_q && !usb_prev_q}; // [R4]
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(int_status_q & int_mask_q);
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_q <= 8'h00;
      end else if (reg_req.rd) begin
         unique case (reg_req.addr)
            osc_ctrl_pkg::ADDR_INTERNAL_OSC_CONTROL:
               rd_data_q <= {osc_enable_q, osc_freq_ready_q, suspend_q, 3'h0,
                             osc_div_select_q}; // [R7]
            osc_ctrl_pkg::ADDR_WAKE_CONTROL:
               rd_data_q <= {6'h00, transceiver_enable_q, vbus_polarity_select_q};
            osc_ctrl_pkg::ADDR_INT_STATUS:
               rd_data_q <= {6'h00, int_status_q};
            osc_ctrl_pkg::ADDR_INT_MASK:
               rd_data_q <= {6'h00, int_mask_q};
            default:
               rd_data_q <= 8'h00;
         endcase
      end else begin
         rd_data_q <= 8'h00;
      end
   end

   assign rd_data            = rd_data_q;
   assign osc_running        = osc_running_q;
   assign core_clock_en      = core_clock_en_q;
   assign transceiver_enable = transceiver_enable_q;
   assign irq                = irq_q;

   property p_suspend_stops;
      @(posedge sys_clk) disable iff (!reset_n)
      (wr_osc && reg_req.wdata[osc_ctrl_pkg::BIT_FORCE_SUSPEND] && !wake) |=> !osc_running_q;
   endproperty
   a_suspend_stops: assert property (p_suspend_stops) else $error("suspend left osc on"); // [R1]

   property p_stay_stopped;
      @(posedge sys_clk) disable iff (!reset_n)
      (suspend_q && !wake) |=> (suspend_q && !osc_running_q);
   endproperty
   a_stay_stopped: assert property (p_stay_stopped) else $error("osc left suspend early"); // [R2]

   property p_wake_restarts;
      @(posedge sys_clk) disable iff (!reset_n)
      (suspend_q && vbus_wake && osc_enable_q) |=> (!suspend_q && osc_running_q);
   endproperty
   a_wake_restarts: assert property (p_wake_restarts) else $error("vbus wake missed"); // [R2]

   // The next enable value is used so that a disabling write in the wake cycle is allowed.
   property p_usb_restarts;
      @(posedge sys_clk) disable iff (!reset_n)
      (suspend_q && usb_wake && osc_enable_d) |=> (!suspend_q && osc_running_q);
   endproperty
   a_usb_restarts: assert property (p_usb_restarts) else $error("usb wake missed"); // [R2]

   property p_wake_without_phy;
      @(posedge sys_clk) disable iff (!reset_n)
      (suspend_q && usb_sync_q && !transceiver_enable_q) |=> !suspend_q;
   endproperty
   a_wake_without_phy: assert property (p_wake_without_phy) else $error("usb wake gated"); // [R3]

   property p_resume_irq;
      @(posedge sys_clk) disable iff (!reset_n)
      (suspend_q && usb_sync_q && !usb_prev_q && int_mask_q[osc_ctrl_pkg::BIT_INT_RESUME])
         |=> int_status_q[osc_ctrl_pkg::BIT_INT_RESUME] ##1 irq_q;
   endproperty
   a_resume_irq: assert property (p_resume_irq) else $error("resume interrupt missing"); // [R4]

   property p_irq_level;
      @(posedge sys_clk) disable iff (!reset_n)
      (|(int_status_q & int_mask_q)) |=> irq_q;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt not raised"); // [R4]

   property p_enable_off;
      @(posedge sys_clk) disable iff (!reset_n)
      !osc_enable_q |-> (!osc_running_q && !osc_freq_ready_q);
   endproperty
   a_enable_off: assert property (p_enable_off) else $error("osc runs while disabled"); // [R6]

   property p_ready_late;
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(osc_running_q) |-> !osc_freq_ready_q[*8];
   endproperty
   a_ready_late: assert property (p_ready_late) else $error("ready before settle time"); // [R7]

   property p_ready_running;
      @(posedge sys_clk) disable iff (!reset_n)
      osc_freq_ready_q |-> osc_running_q;
   endproperty
   a_ready_running: assert property (p_ready_running) else $error("ready while stopped"); // [R7]

   sequence s_div2_gap;
      (core_clock_en_q && osc_running_q && osc_div_select_q == osc_ctrl_pkg::DIV_BY2)
      ##1 (osc_running_q && osc_div_select_q == osc_ctrl_pkg::DIV_BY2);
   endsequence
   property p_div2;
      @(posedge sys_clk) disable iff (!reset_n)
      s_div2_gap |-> !core_clock_en_q ##1 (!osc_running_q || core_clock_en_q);
   endproperty
   a_div2: assert property (p_div2) else $error("divide by two cadence wrong"); // [R8]

   sequence s_div8_run;
      (core_clock_en_q && osc_running_q && osc_div_select_q == osc_ctrl_pkg::DIV_BY8)
      ##1 (osc_running_q && osc_div_select_q == osc_ctrl_pkg::DIV_BY8)[*7];
   endsequence
   property p_div8;
      @(posedge sys_clk) disable iff (!reset_n)
      s_div8_run |=> (!osc_running_q || core_clock_en_q);
   endproperty
   a_div8: assert property (p_div8) else $error("divide by eight cadence wrong"); // [R10] [R9]

endmodule

// ==== src/osc_ctrl_pkg.sv ====
/*
 * Shared definitions for the internal oscillator control block: register
 * offsets, field positions, reset values, divide codes and timing counts.
 * Assumes a single 10 MHz core clock and an 8-bit register port.
 */
package osc_ctrl_pkg;

   localparam int unsigned SYS_CLK_PERIOD_NS = 100;
   // Start-up time from oscillator enable to programmed frequency.
   localparam int unsigned OSC_SETTLE_NS     = 1000;
   localparam int unsigned OSC_SETTLE_CYC    =
      (OSC_SETTLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

   localparam logic [7:0] ADDR_INTERNAL_OSC_CONTROL = 8'hB2;
   localparam logic [7:0] ADDR_WAKE_CONTROL         = 8'hC0;
   localparam logic [7:0] ADDR_INT_STATUS           = 8'hC1;
   localparam logic [7:0] ADDR_INT_MASK             = 8'hC2;

   localparam logic [7:0] OSC_CONTROL_RESET = 8'h80;
   localparam logic [7:0] WAKE_CONTROL_RESET = 8'h00;
   localparam logic [7:0] INT_RESET         = 8'h00;

   localparam int unsigned BIT_OSC_ENABLE     = 7;
   localparam int unsigned BIT_OSC_FREQ_READY = 6;
   localparam int unsigned BIT_FORCE_SUSPEND  = 5;
   localparam int unsigned BIT_DIV_HI         = 1;
   localparam int unsigned BIT_DIV_LO         = 0;

   localparam int unsigned BIT_VBUS_POLARITY  = 0;
   localparam int unsigned BIT_TRANSCEIVER_EN = 1;

   localparam int unsigned INT_BITS        = 2;
   localparam int unsigned BIT_INT_RESUME  = 0;
   localparam int unsigned BIT_INT_VBUS    = 1;

   localparam logic [1:0] DIV_BY8 = 2'h0;
   localparam logic [1:0] DIV_BY4 = 2'h1;
   localparam logic [1:0] DIV_BY2 = 2'h2;
   localparam logic [1:0] DIV_BY1 = 2'h3;

   localparam logic [2:0] LIMIT_BY8 = 3'h7;
   localparam logic [2:0] LIMIT_BY4 = 3'h3;
   localparam logic [2:0] LIMIT_BY2 = 3'h1;
   localparam logic [2:0] LIMIT_BY1 = 3'h0;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

endpackage

// ==== tb/tb_internal_osc_suspend_ctrl.sv ====
/*
 * Self-checking bench for the internal oscillator suspend control block.
 * Assumes the design package and the USB wake model beside it.
 */
`define CHK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         errors++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end

module tb_internal_osc_suspend_ctrl;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [7:0] OSC  = osc_ctrl_pkg::ADDR_INTERNAL_OSC_CONTROL;
   localparam logic [7:0] WAKE = osc_ctrl_pkg::ADDR_WAKE_CONTROL;
   localparam logic [7:0] STAT = osc_ctrl_pkg::ADDR_INT_STATUS;
   localparam logic [7:0] MASK = osc_ctrl_pkg::ADDR_INT_MASK;

   logic                   sys_clk;
   logic                   reset_n;
   osc_ctrl_pkg::reg_req_t req;
   logic [7:0]             rd_data;
   logic                   usb_nonidle;
   logic                   vbus_level;
   logic                   osc_running;
   logic                   core_clock_en;
   logic                   transceiver_enable;
   logic                   irq;
   logic                   resume_go;
   logic [3:0]             resume_delay;
   logic                   vbus_on;
   int                     errors = 0;
   int                     n_compared = 0;
   int                     n;

   internal_osc_suspend_ctrl u_internal_osc_suspend_ctrl (
      .sys_clk(sys_clk), .reset_n(reset_n), .reg_req(req), .rd_data(rd_data),
      .usb_nonidle(usb_nonidle), .vbus_level(vbus_level), .osc_running(osc_running),
      .core_clock_en(core_clock_en), .transceiver_enable(transceiver_enable), .irq(irq));

   usb_wake_model u_usb_wake_model (
      .sys_clk(sys_clk), .resume_go(resume_go), .resume_delay(resume_delay),
      .vbus_on(vbus_on), .usb_nonidle(usb_nonidle), .vbus_level(vbus_level));

   task automatic end_of_test();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1;
      `CHK(what, exp, rd_data)
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask

   // Counts edges between two core clock pulses; a hung divider gives 20.
   task automatic measure(output int cnt);
      cnt = 0;
      #1;
      for (int i = 0; i < 20 && core_clock_en !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      do begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end while (core_clock_en !== 1'b1 && cnt < 20);
   endtask

   task automatic wait_osc();
      int i;
      for (i = 0; i < 40 && osc_running !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      if (i == 40) begin
         errors++;
         $display("wrong value osc_running expected 1 seen 0");
         end_of_test();
      end
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   initial begin
      reset_n = 1'b0;
      req = '0;
      resume_go = 1'b0;
      resume_delay = 4'h0;
      vbus_on = 1'b0;
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      reg_rd(OSC, 8'h80, "osc control at reset");
      `CHK("osc_running at reset", 1'b1, osc_running)
      measure(n);
      `CHK("default period", 8, n)
      reg_rd(WAKE, 8'h00, "wake control at reset");
      reg_rd(STAT, 8'h00, "status at reset");
      reg_rd(MASK, 8'h00, "mask at reset");
      reg_rd(8'h55, 8'h00, "unmapped read");
      settle(15);
      reg_rd(OSC, 8'hC0, "ready after settle");
      for (int c = 0; c < 4; c++) begin
         reg_wr(OSC, 8'h80 | 8'(c));
         measure(n);
         measure(n);
         `CHK("divided period", 8 >> c, n)
         reg_rd(OSC, 8'hC0 | 8'(c), "divide readback");
      end
      // Polarity one keeps the idle VBUS level from waking the oscillator at once.
      reg_wr(WAKE, 8'h01);
      reg_wr(MASK, 8'h01);
      for (int k = 0; k < 2; k++) begin
         reg_wr(OSC, 8'hA3);
         settle(1);
         `CHK("osc_running after suspend", 1'b0, osc_running)
         reg_rd(OSC, 8'hA3, "suspended readback");
         settle(4);
         `CHK("osc_running held", 1'b0, osc_running)
         `CHK("irq before resume", 1'b0, irq)
         @(posedge sys_clk);
         resume_go <= 1'b1;
         resume_delay <= (k == 0) ? 4'h0 : 4'h9;
         @(posedge sys_clk);
         resume_go <= 1'b0;
         wait_osc();
         settle(2);
         `CHK("irq on resume", 1'b1, irq)
         reg_rd(STAT, 8'h01, "resume status");
         reg_wr(WAKE, 8'h03);
         settle(1);
         `CHK("transceiver_enable", 1'b1, transceiver_enable)
         reg_wr(STAT, 8'h01);
         settle(2);
         `CHK("irq after clear", 1'b0, irq)
      end
      reg_wr(OSC, 8'hA3);
      settle(4);
      `CHK("osc_running vbus wait", 1'b0, osc_running)
      @(posedge sys_clk);
      vbus_on <= 1'b1;
      wait_osc();
      reg_rd(STAT, 8'h02, "vbus status");
      settle(1);
      `CHK("irq masked", 1'b0, irq)
      reg_wr(MASK, 8'h03);
      settle(2);
      `CHK("irq unmasked", 1'b1, irq)
      reg_wr(STAT, 8'h02);
      settle(2);
      `CHK("irq vbus cleared", 1'b0, irq)
      reg_wr(OSC, 8'h03);
      settle(1);
      `CHK("osc_running disabled", 1'b0, osc_running)
      reg_rd(OSC, 8'h03, "disabled readback");
      reg_wr(OSC, 8'h83);
      settle(1);
      `CHK("osc_running enabled", 1'b1, osc_running)
      settle(15);
      reg_rd(OSC, 8'hC3, "ready again");
      end_of_test();
   end
endmodule

// ==== tb/usb_wake_model.sv ====
/*
 * Behavioural model of the USB transceiver and VBUS level detector.
 * Assumes the bench pulses resume_go for one cycle to request resume signalling.
 */
module usb_wake_model (
   input  wire logic       sys_clk,
   input  wire logic       resume_go,
   input  wire logic [3:0] resume_delay,
   input  wire logic       vbus_on,
   output logic            usb_nonidle,
   output logic            vbus_level
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [3:0] wait_q  = 4'h0;
   logic [2:0] burst_q = 3'h0;

   // A delay of zero answers promptly; larger values model a slow host.
   always_ff @(posedge sys_clk) begin
      if (resume_go) begin
         wait_q  <= resume_delay;
         burst_q <= 3'h4;
      end else if (wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end else if (burst_q != 3'h0) begin
         burst_q <= burst_q - 3'h1;
      end
   end

   // Detection runs whatever the transceiver enable says, so wake never needs it.
   assign usb_nonidle = (wait_q == 4'h0) && (burst_q != 3'h0);
   assign vbus_level  = vbus_on;
endmodule
